// ==== egb_pkg.sv ====
// exposure, gain and black-level control: shared constants
// assumes one clock at CLK_MHZ; field bits numbered from the lsb
`default_nettype none
package egb_pkg;
    // csr byte addresses
    localparam logic [31:0] BLACK_LEVEL_CONTROL_ADDR = 32'hf0f00800;
    localparam logic [31:0] TARGET_LEVEL_CONTROL_ADDR = 32'hf0f00804;
    localparam logic [31:0] GAIN_CONTROL_ADDR = 32'hf0f00820;
    // common feature field layout
    localparam int PRESENT_BIT = 0;
    localparam int ABS_BIT = 1;
    localparam int ONE_PUSH_BIT = 5;
    localparam int ON_OFF_BIT = 6;
    localparam int AUTO_BIT = 7;
    localparam int VALUE_LSB = 20;
    localparam int VALUE_W = 12;
    // value ranges and reset values
    localparam logic [11:0] TARGET_MIN = 12'h032;
    localparam logic [11:0] TARGET_MAX = 12'h0cd;
    localparam logic [11:0] TARGET_RESET = 12'h080;
    localparam logic [11:0] GAIN_MIN = 12'h000;
    localparam logic [11:0] GAIN_MAX = 12'h2a8;
    localparam logic [11:0] GAIN_RESET = 12'h000;
    localparam logic [11:0] BLACK_MIN = 12'h000;
    localparam logic [11:0] BLACK_MAX = 12'h100;
    localparam logic [11:0] BLACK_RESET = 12'h000;
    // analog slope of one gain code, micro-dB
    localparam int GAIN_UDB_PER_STEP = 35400;
    // auto loop tuning
    localparam logic [8:0] LEVEL_TOL = 9'h002;
    localparam logic [11:0] GAIN_STEP = 12'h004;
    // one-push timeout
    localparam int CLK_MHZ = 200;
    localparam int ONE_PUSH_TIME_US = 5000;
    localparam int ONE_PUSH_CYC = ONE_PUSH_TIME_US * CLK_MHZ;

    // limit a value field to its legal range
    function automatic logic [11:0] clampVal(input logic [11:0] v,
                                             input logic [11:0] lo,
                                             input logic [11:0] hi);
        clampVal = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clampVal
endpackage : egb_pkg
`default_nettype wire

// ==== egb_feature.sv ====
// one feature control register in the common field layout
// assumes wrStrobe is a one-cycle pulse already decoded for this address
`timescale 1ns/1ps
`default_nettype none
module egb_feature
    import egb_pkg::*;
#(
    parameter bit PRESENT = 1'b1,
    parameter logic [11:0] VAL_MIN = 12'h000,
    parameter logic [11:0] VAL_MAX = 12'hfff,
    parameter logic [11:0] VAL_RESET = 12'h000
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wrStrobe,
    input wire logic [31:0] wrWord,
    input wire logic opDone,
    output logic [11:0] value,
    output logic absSel,
    output logic onOff,
    output logic autoMode,
    output logic busy,
    output logic [31:0] readWord
);
    logic [11:0] wrValue;
    logic valueOpen;

    assign wrValue = wrWord[VALUE_LSB +: VALUE_W];
    // value is taken only with the switch on and manual mode in the same word
    assign valueOpen = wrWord[ON_OFF_BIT] & ~wrWord[AUTO_BIT];

    // control bits; an absent feature keeps them all low
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            absSel <= 1'b0;
            onOff <= 1'b0;
            autoMode <= 1'b0;
        end else if (wrStrobe && PRESENT) begin
            absSel <= wrWord[ABS_BIT];
            onOff <= wrWord[ON_OFF_BIT];
            autoMode <= wrWord[AUTO_BIT];
        end
    end

    // value field, clamped into range
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            value <= VAL_RESET;
        end else if (wrStrobe && PRESENT && valueOpen) begin
            value <= clampVal(wrValue, VAL_MIN, VAL_MAX);
        end
    end

    // one-push busy; a new start wins over a done in the same cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy <= 1'b0;
        end else if (wrStrobe && PRESENT && wrWord[ONE_PUSH_BIT] && !wrWord[AUTO_BIT]) begin
            busy <= 1'b1;
        end else if (opDone) begin
            busy <= 1'b0;
        end
    end

    // read image; reserved bits stay zero
    always_comb begin
        readWord = 32'h0000_0000;
        readWord[PRESENT_BIT] = PRESENT;
        readWord[ABS_BIT] = absSel;
        readWord[ONE_PUSH_BIT] = busy;
        readWord[ON_OFF_BIT] = onOff;
        readWord[AUTO_BIT] = autoMode;
        readWord[VALUE_LSB +: VALUE_W] = value;
    end
endmodule : egb_feature
`default_nettype wire

// ==== egb_onepush.sv ====
// one-push timer: ends a single adjustment on settle or on timeout
// assumes busy is held by the feature register until done is seen
`timescale 1ns/1ps
`default_nettype none
module egb_onepush #(
    parameter int CYC = 1000000
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic busy,
    input wire logic settle,
    output logic done
);
    logic [31:0] count;

    // count only while an operation runs
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= 32'h0000_0000;
        end else if (!busy || done) begin
            count <= 32'h0000_0000;
        end else begin
            count <= count + 32'h0000_0001;
        end
    end

    // a loop that never settles must still free the busy bit
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            done <= 1'b0;
        end else begin
            done <= busy && !done && (settle || count >= 32'(CYC - 1));
        end
    end
endmodule : egb_onepush
`default_nettype wire

// ==== egb_csr_top.sv ====
// file holds the csr bank for target level, black level and gain,
// plus the automatic gain loop that the target level steers.
// assumes a register port already decoded from the camera bus,
// and a per-frame mean brightness measurement from the video path.
`timescale 1ns/1ps
`default_nettype none
module egb_csr_top
    import egb_pkg::*;
#(
    parameter int ONE_PUSH_MAX = ONE_PUSH_CYC,
    parameter logic [11:0] GAIN_LO = GAIN_MIN,
    parameter logic [11:0] GAIN_HI = GAIN_MAX
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic csrWrite,
    input wire logic csrRead,
    input wire logic [31:0] csrAddr,
    input wire logic [31:0] csrWrData,
    output logic [31:0] csrRdData,
    output logic csrRdValid,
    output logic csrAddrErr,
    input wire logic [11:0] absGain,
    input wire logic [11:0] absTarget,
    input wire logic [11:0] absBlack,
    input wire logic [7:0] avgLevel,
    input wire logic avgValid,
    output logic [11:0] gainCode,
    output logic [11:0] blackOffset,
    output logic [7:0] targetLevel,
    output logic autoSettled
);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------

    logic selBlack;
    logic selTarget;
    logic selGain;
    logic selAny;

    // full 32-bit match; anything else is unmapped
    assign selBlack = (csrAddr == BLACK_LEVEL_CONTROL_ADDR);
    assign selTarget = (csrAddr == TARGET_LEVEL_CONTROL_ADDR);
    assign selGain = (csrAddr == GAIN_CONTROL_ADDR);
    assign selAny = selBlack | selTarget | selGain;

    // ------------------------------------------------------------
    // feature registers
    // ------------------------------------------------------------

    logic [11:0] blackValue;
    logic blackAbs;
    logic blackOn;
    logic blackAuto;
    logic blackBusy;
    logic [31:0] blackWord;

    logic [11:0] targetValue;
    logic targetAbs;
    logic targetOn;
    logic targetAuto;
    logic targetBusy;
    logic [31:0] targetWord;

    logic [11:0] gainValue;
    logic gainAbs;
    logic gainOn;
    logic gainAuto;
    logic gainBusy;
    logic [31:0] gainWord;

    logic gainDone;
    logic settlePulse;

    // black level: 1/16 gray steps, 256 codes span 16 gray values
    egb_feature #(
        .PRESENT(1'b1),
        .VAL_MIN(BLACK_MIN),
        .VAL_MAX(BLACK_MAX),
        .VAL_RESET(BLACK_RESET)
    ) uBlack (
        .clk(clk),
        .rst_b(rst_b),
        .wrStrobe(csrWrite && selBlack),
        .wrWord(csrWrData),
        .opDone(blackBusy),
        .value(blackValue),
        .absSel(blackAbs),
        .onOff(blackOn),
        .autoMode(blackAuto),
        .busy(blackBusy),
        .readWord(blackWord)
    );

    // target level: the device clamps values outside its range to its ends
    egb_feature #(
        .PRESENT(1'b1),
        .VAL_MIN(TARGET_MIN),
        .VAL_MAX(TARGET_MAX),
        .VAL_RESET(TARGET_RESET)
    ) uTarget (
        .clk(clk),
        .rst_b(rst_b),
        .wrStrobe(csrWrite && selTarget),
        .wrWord(csrWrData),
        .opDone(targetBusy),
        .value(targetValue),
        .absSel(targetAbs),
        .onOff(targetOn),
        .autoMode(targetAuto),
        .busy(targetBusy),
        .readWord(targetWord)
    );

    // gain: codes 0..680, the loop below ends its one-push
    egb_feature #(
        .PRESENT(1'b1),
        .VAL_MIN(GAIN_LO),
        .VAL_MAX(GAIN_HI),
        .VAL_RESET(GAIN_RESET)
    ) uGain (
        .clk(clk),
        .rst_b(rst_b),
        .wrStrobe(csrWrite && selGain),
        .wrWord(csrWrData),
        .opDone(gainDone),
        .value(gainValue),
        .absSel(gainAbs),
        .onOff(gainOn),
        .autoMode(gainAuto),
        .busy(gainBusy),
        .readWord(gainWord)
    );

    // single adjustment ends when the loop settles or times out
    // the timeout keeps a scene that never settles from pinning busy
    egb_onepush #(
        .CYC(ONE_PUSH_MAX)
    ) uGainPush (
        .clk(clk),
        .rst_b(rst_b),
        .busy(gainBusy),
        .settle(settlePulse),
        .done(gainDone)
    );

    // ------------------------------------------------------------
    // setting selection
    // ------------------------------------------------------------

    logic [11:0] manualGain;
    logic [11:0] targetSel;
    logic [11:0] blackSel;
    logic loopRun;

    // absolute input or value field; the absolute path meets the same clamp as the field,
    // so a wild absolute input can never leave the legal range
    function automatic logic [11:0] pickSetting(input logic useAbs,
                                                input logic [11:0] absVal,
                                                input logic [11:0] fieldVal,
                                                input logic [11:0] lo,
                                                input logic [11:0] hi);
        pickSetting = useAbs ? clampVal(absVal, lo, hi) : fieldVal;
    endfunction : pickSetting

    // absolute select replaces the value field
    assign manualGain = pickSetting(gainAbs, absGain, gainValue, GAIN_LO, GAIN_HI);
    assign targetSel = pickSetting(targetAbs, absTarget, targetValue,
                                   TARGET_MIN, TARGET_MAX);
    assign blackSel = pickSetting(blackAbs, absBlack, blackValue,
                                  BLACK_MIN, BLACK_MAX);

    // the target steers nothing unless auto gain is really running;
    // a one-push run borrows the loop in manual mode until it ends
    assign loopRun = gainOn && (gainAuto || gainBusy) && targetOn;

    // ------------------------------------------------------------
    // automatic gain loop
    // ------------------------------------------------------------

    logic [8:0] levelLow;
    logic [8:0] levelHigh;
    logic [8:0] targetWide;
    logic tooDark;
    logic tooBright;
    logic [11:0] gainUp;
    logic [11:0] gainDown;
    logic [11:0] loopGain;

    // widen before adding the tolerance so 255 cannot wrap;
    // the dead band either side of the target stops the loop hunting
    // one step up and down on every frame
    assign levelLow = {1'b0, avgLevel} + LEVEL_TOL;
    assign levelHigh = {1'b0, avgLevel};
    assign targetWide = {1'b0, targetSel[7:0]};
    assign tooDark = (levelLow < targetWide);
    assign tooBright = (levelHigh > targetWide + LEVEL_TOL);

    // step sums stay in 12 bits; the clamp keeps them legal
    assign gainUp = (loopGain > GAIN_HI - GAIN_STEP) ? GAIN_HI : loopGain + GAIN_STEP;
    assign gainDown = (loopGain < GAIN_LO + GAIN_STEP) ? GAIN_LO : loopGain - GAIN_STEP;

    // loop gain tracks the manual setting while the loop is idle,
    // so entering auto starts from the picture already on screen
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            loopGain <= GAIN_RESET;
        end else if (!loopRun) begin
            loopGain <= manualGain;
        end else if (avgValid && tooDark) begin
            loopGain <= clampVal(gainUp, GAIN_LO, GAIN_HI);
        end else if (avgValid && tooBright) begin
            loopGain <= clampVal(gainDown, GAIN_LO, GAIN_HI);
        end
    end

    // a measurement inside the band counts as settled
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            settlePulse <= 1'b0;
        end else begin
            settlePulse <= loopRun && avgValid && !tooDark && !tooBright;
        end
    end

    // settled level drops at the next miss or when the loop stops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            autoSettled <= 1'b0;
        end else if (!loopRun) begin
            autoSettled <= 1'b0;
        end else if (avgValid) begin
            autoSettled <= !tooDark && !tooBright;
        end
    end

    // ------------------------------------------------------------
    // analog outputs
    // ------------------------------------------------------------

    // gain goes straight to the amplifier; no frame sync needed,
    // so a change may land mid-frame, the price of one-write updates;
    // one analog code is worth GAIN_UDB_PER_STEP micro-dB
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gainCode <= GAIN_RESET;
        end else if (!gainOn) begin
            gainCode <= GAIN_LO;
        end else begin
            gainCode <= loopRun ? loopGain : manualGain;
        end
    end

    // offset depends only on its own register and absBlack, never on gain
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            blackOffset <= BLACK_RESET;
        end else if (!blackOn) begin
            blackOffset <= BLACK_MIN;
        end else begin
            blackOffset <= blackSel;
        end
    end

    // target seen by the shutter side as well
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            targetLevel <= TARGET_RESET[7:0];
        end else begin
            targetLevel <= targetSel[7:0];
        end
    end

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------

    logic [31:0] next_rdData;

    // unmapped reads return zero rather than stale data
    always_comb begin
        next_rdData = 32'h0000_0000;
        if (selBlack) begin
            next_rdData = blackWord;
        end else if (selTarget) begin
            next_rdData = targetWord;
        end else if (selGain) begin
            next_rdData = gainWord;
        end
    end

    // data and valid appear together one cycle after the read
    // a write in the same cycle lands later, so the read sees old contents
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            csrRdData <= 32'h0000_0000;
            csrRdValid <= 1'b0;
        end else begin
            csrRdValid <= csrRead;
            if (csrRead) begin
                csrRdData <= next_rdData;
            end
        end
    end

    // flag any access, read or write, to an address we do not own
    // writes count too, so a mistyped address never vanishes unseen
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            csrAddrErr <= 1'b0;
        end else begin
            csrAddrErr <= (csrRead || csrWrite) && !selAny;
        end
    end

    // the value field carries no meaning when readout is absent;
    // software side handles it, the hardware still returns value

endmodule : egb_csr_top
`default_nettype wire

// ==== egb_csr_checker.sv ====
// checker: csr port protocol and output ranges of the control bank
// assumes binding to egb_csr_top, one clock, reset active low
`timescale 1ns/1ps
`default_nettype none
module egb_csr_checker
    import egb_pkg::*;
#(
    parameter logic [11:0] GAIN_HI = GAIN_MAX
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic csrWrite,
    input wire logic csrRead,
    input wire logic [31:0] csrAddr,
    input wire logic [31:0] csrWrData,
    input wire logic [31:0] csrRdData,
    input wire logic csrRdValid,
    input wire logic csrAddrErr,
    input wire logic [11:0] absBlack,
    input wire logic [11:0] gainCode,
    input wire logic [11:0] blackOffset,
    input wire logic [7:0] targetLevel
);
    // ------------------------------
    // decode
    // ------------------------------
    logic hit;
    logic stray;
    // one shared decode, so the stray and read properties agree on the map
    assign hit = (csrAddr == BLACK_LEVEL_CONTROL_ADDR) || (csrAddr == TARGET_LEVEL_CONTROL_ADDR)
        || (csrAddr == GAIN_CONTROL_ADDR);
    assign stray = (csrRead || csrWrite) && !hit;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // ------------------------------
    // properties
    // ------------------------------
    // gain write that switches the feature off
    sequence s_gain_off;
        csrWrite && (csrAddr == GAIN_CONTROL_ADDR) && !csrWrData[ON_OFF_BIT];
    endsequence
    // gain write with no black write in the cycle before it
    sequence s_lone_gain;
        !(csrWrite && (csrAddr == BLACK_LEVEL_CONTROL_ADDR)) ##1
            (csrWrite && (csrAddr == GAIN_CONTROL_ADDR) && $stable(absBlack));
    endsequence
    a_read_answered: assert property (csrRead |=> csrRdValid)
        else $error("read not answered");
    a_answer_caused: assert property (csrRdValid |-> $past(csrRead))
        else $error("read answer without read");
    a_stray_flagged: assert property (stray |=> csrAddrErr
        && (!csrRdValid || csrRdData == 32'h0))
        else $error("unmapped access not refused");
    a_flag_caused: assert property (csrAddrErr |-> $past(stray))
        else $error("address error without cause");
    a_present_one: assert property (csrRead && hit |=> csrRdData[PRESENT_BIT])
        else $error("presence flag low");
    a_reserved_zero: assert property (csrRead && hit |=> csrRdData[4:2] == 3'h0
        && csrRdData[19:8] == 12'h000)
        else $error("reserved bits not zero");
    a_rdata_held: assert property (!csrRead |=> $stable(csrRdData))
        else $error("read data moved without read");
    a_gain_off: assert property (s_gain_off |-> ##2 (gainCode == 12'h000))
        else $error("gain code not zero when off");
    a_gain_limit: assert property (gainCode <= GAIN_HI)
        else $error("gain code out of range");
    a_black_limit: assert property (blackOffset <= BLACK_MAX)
        else $error("black offset out of range");
    a_target_band: assert property ({4'h0, targetLevel} >= TARGET_MIN
        && {4'h0, targetLevel} <= TARGET_MAX)
        else $error("target level out of range");
    a_black_kept: assert property (s_lone_gain |-> ##2
        (blackOffset == $past(blackOffset, 2)))
        else $error("gain write moved black offset");
endmodule : egb_csr_checker

bind egb_csr_top egb_csr_checker #(.GAIN_HI(GAIN_HI)) egb_csr_checker_inst (
    .clk(clk), .rst_b(rst_b), .csrWrite(csrWrite), .csrRead(csrRead), .csrAddr(csrAddr),
    .csrWrData(csrWrData), .csrRdData(csrRdData), .csrRdValid(csrRdValid),
    .csrAddrErr(csrAddrErr), .absBlack(absBlack), .gainCode(gainCode),
    .blackOffset(blackOffset), .targetLevel(targetLevel)
);
`default_nettype wire

// ==== egb_scene_model.sv ====
// scene model: mean frame brightness that rises with the gain code
// assumes one clock; measures every eight cycles while enabled
`timescale 1ns/1ps
`default_nettype none
module egb_scene_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic enable,
    input wire logic [11:0] gainCode,
    output logic [7:0] avgLevel,
    output logic avgValid
);
    logic [2:0] frameCnt;
    // brightness is gain over four, so the loop has an exact fixed point
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            frameCnt <= 3'h0;
            avgValid <= 1'b0;
            avgLevel <= 8'h00;
        end else begin
            frameCnt <= frameCnt + 3'h1;
            avgValid <= enable && (frameCnt == 3'h7);
            if (enable && (frameCnt == 3'h7)) begin
                avgLevel <= gainCode[9:2];
            end else begin
                avgLevel <= ~avgLevel; // meaningless between frames
            end
        end
    end
endmodule : egb_scene_model
`default_nettype wire

// ==== testbench.sv ====
// testbench: csr bank driven through its register port
// assumes egb_csr_top, scene model and checker compiled before it
`timescale 1ns/1ps
`default_nettype none
module testbench
    import egb_pkg::*;
();
    localparam logic [31:0] BLK = BLACK_LEVEL_CONTROL_ADDR;
    localparam logic [31:0] TGT = TARGET_LEVEL_CONTROL_ADDR;
    localparam logic [31:0] GN = GAIN_CONTROL_ADDR;
    logic clk, rst_b, csrWrite, csrRead, csrRdValid, csrAddrErr, avgValid, autoSettled, sceneOn;
    logic [31:0] csrAddr, csrWrData, csrRdData;
    logic [11:0] absGain, absTarget, absBlack, gainCode, blackOffset;
    logic [7:0] avgLevel, targetLevel;
    int checked, miscompares;
    // short one-push limit keeps the timeout case brief
    egb_csr_top #(.ONE_PUSH_MAX(20)) egb_csr_top_inst (
        .clk(clk), .rst_b(rst_b), .csrWrite(csrWrite), .csrRead(csrRead), .csrAddr(csrAddr),
        .csrWrData(csrWrData), .csrRdData(csrRdData), .csrRdValid(csrRdValid),
        .csrAddrErr(csrAddrErr), .absGain(absGain), .absTarget(absTarget), .absBlack(absBlack),
        .avgLevel(avgLevel), .avgValid(avgValid), .gainCode(gainCode),
        .blackOffset(blackOffset), .targetLevel(targetLevel), .autoSettled(autoSettled));
    egb_scene_model egb_scene_model_inst (.clk(clk), .rst_b(rst_b), .enable(sceneOn),
        .gainCode(gainCode), .avgLevel(avgLevel), .avgValid(avgValid));
    // ------------------------------
    // tasks
    // ------------------------------
    function automatic logic [31:0] word(input logic [11:0] v, input logic [7:0] c);
        return {v, 12'h000, c};
    endfunction : word
    task automatic stop_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if ((miscompares == 0) && (checked > 0)) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            miscompares++;
        end
    endtask : chk
    // request held for one sampling edge, released right after it
    task automatic csr_wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        csrWrite <= 1'b1;
        csrAddr <= a;
        csrWrData <= d;
        @(posedge clk);
        csrWrite <= 1'b0;
    endtask : csr_wr
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        @(posedge clk);
        csrRead <= 1'b1;
        csrAddr <= a;
        @(posedge clk);
        csrRead <= 1'b0;
        #1;
        chk(32'(csrRdValid), 32'h1);
        chk(csrRdData, exp);
    endtask : rd_chk
    // read issued the cycle after the write, catching a short busy
    task automatic wr_rd(input logic [31:0] a, input logic [31:0] d, input logic [31:0] exp);
        csr_wr(a, d);
        csrRead <= 1'b1;
        @(posedge clk);
        csrRead <= 1'b0;
        #1;
        chk(csrRdData, exp);
    endtask : wr_rd
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask : settle
    // bounded wait for the auto loop to land on a gain code
    task automatic wait_gain(input logic [11:0] exp);
        int n;
        n = 0;
        while ((gainCode !== exp) && (n < 8000)) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(32'(gainCode), 32'(exp));
        if (n >= 8000) stop_test();
    endtask : wait_gain
    // ------------------------------
    // clock, reset and sequence
    // ------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        {rst_b, csrWrite, csrRead, sceneOn} = 4'h0;
        {csrAddr, csrWrData} = 64'h0;
        {absGain, absTarget, absBlack} = 36'h0;
        checked = 0;
        miscompares = 0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        rd_chk(BLK, word(12'h000, 8'h01));
        rd_chk(TGT, word(12'h080, 8'h01));
        rd_chk(GN, word(12'h000, 8'h01));
        rd_chk(32'hf0f00808, 32'h0);
        chk(32'(csrAddrErr), 32'h1);
        csr_wr(32'hf0f00808, 32'hffffffff);
        #1;
        chk(32'(csrAddrErr), 32'h1);
        $display("test reset and map done");
        csr_wr(BLK, word(12'h12c, 8'h40));
        rd_chk(BLK, word(12'h100, 8'h41));
        chk(32'(blackOffset), 32'h100);
        csr_wr(BLK, 32'h010fff5c);
        rd_chk(BLK, word(12'h010, 8'h41));
        wr_rd(BLK, word(12'h010, 8'h60), word(12'h010, 8'h61));
        rd_chk(BLK, word(12'h010, 8'h41));
        chk(32'(blackOffset), 32'h010);
        $display("test black level done");
        csr_wr(TGT, word(12'h00a, 8'h40));
        rd_chk(TGT, word(12'h032, 8'h41));
        chk(32'(targetLevel), 32'h32);
        csr_wr(TGT, word(12'h0fa, 8'h40));
        rd_chk(TGT, word(12'h0cd, 8'h41));
        csr_wr(TGT, word(12'h000, 8'h00));
        rd_chk(TGT, word(12'h0cd, 8'h01));
        $display("test target level done");
        csr_wr(GN, word(12'h064, 8'h40));
        settle();
        chk(32'(gainCode), 32'h064);
        chk(32'(blackOffset), 32'h010);
        csr_wr(GN, word(12'hfff, 8'h40));
        rd_chk(GN, word(12'h2a8, 8'h41));
        csr_wr(GN, word(12'h064, 8'h40));
        csr_wr(GN, word(12'h0c8, 8'hc0));
        rd_chk(GN, word(12'h064, 8'hc1));
        chk(32'(gainCode), 32'h064);
        csr_wr(GN, word(12'h12c, 8'h00));
        rd_chk(GN, word(12'h064, 8'h01));
        chk(32'(gainCode), 32'h000);
        @(posedge clk);
        absGain <= 12'hfff;
        csr_wr(GN, word(12'h000, 8'h42));
        settle();
        chk(32'(gainCode), 32'h2a8);
        @(posedge clk);
        absGain <= 12'h0c8;
        settle();
        chk(32'(gainCode), 32'h0c8);
        $display("test manual gain done");
        csr_wr(GN, word(12'h064, 8'h40));
        csr_wr(TGT, word(12'h096, 8'h40));
        repeat (10) @(posedge clk);
        #1;
        chk(32'(gainCode), 32'h064);
        chk(32'(targetLevel), 32'h96);
        wr_rd(GN, word(12'h064, 8'h60), word(12'h064, 8'h61));
        repeat (30) @(posedge clk);
        rd_chk(GN, word(12'h064, 8'h41));
        $display("test one push done");
        csr_wr(GN, word(12'h000, 8'h40));
        csr_wr(TGT, word(12'h064, 8'h40));
        sceneOn <= 1'b1;
        csr_wr(GN, word(12'h000, 8'hc0));
        wait_gain(12'h188);
        repeat (20) @(posedge clk);
        #1;
        chk(32'(autoSettled), 32'h1);
        csr_wr(TGT, word(12'h096, 8'h40));
        wait_gain(12'h250);
        csr_wr(TGT, word(12'h0cd, 8'h40));
        wait_gain(12'h2a8);
        repeat (40) @(posedge clk);
        #1;
        chk(32'(gainCode), 32'h2a8);
        chk(32'(autoSettled), 32'h0);
        $display("test auto loop done");
        @(posedge clk);
        absBlack <= 12'h1ff;
        absTarget <= 12'h0b4;
        csr_wr(BLK, word(12'h000, 8'h42));
        csr_wr(TGT, word(12'h000, 8'h42));
        settle();
        chk(32'(blackOffset), 32'h100);
        chk(32'(targetLevel), 32'hb4);
        $display("test absolute path done");
        stop_test();
    end
endmodule : testbench
`default_nettype wire
